/* include/watchdog_cfg.svh */
// Behaviour
// R01 - Kick in closed window issues reset
// R02 - Open window starts when closed window ends
// R03 - Default spans come from fuse inputs
// R04 - Counter advances on synchronised 1kHz oscillator
// R05 - Change needs unlock and change bit
// R06 - Lock fuse freezes main control register
// R07 - Watchdog keeps configured settings after resets
// R08 - Locked: closed span frozen, mode writable
// R09 - Timeout code doubles from 8 cycles
// R10 - Window mode: timeout sets open span
// R11 - Timeout codes above 1010 never reset
// R12 - Main fields change only with change bit
// R13 - Main bit 1 enables the watchdog
// R14 - Main bit 0 is change gate
// R15 - Closed span uses same coding, normal ignores
// R16 - Closed codes above 1010 give no window
// R17 - Window fields change only with change bit
// R18 - Window bit 1 selects window mode
// R19 - Window change bit ignores lock fuse
// R20 - Busy flag marks pending domain crossing
// R21 - Crossing happens only while enabled
// R22 - Reserved bits read as zero
// R23 - Normal mode: no kick means reset
// R24 - Each kick restarts the period
// R25 - Window mode: early or late kick resets
// R26 - Open-window kick restarts closed window
// R27 - Old settings run until crossing ends
`ifndef WATCHDOG_CFG_SVH
`define WATCHDOG_CFG_SVH
`define MAIN_IDX 2'h0
`define WINDOW_IDX 2'h1
`define STATUS_IDX 2'h2
`define SEL_POS 2
`define GATE_POS 0
`define FLAG_POS 1
`define SPAN_BASE 14'h0008
`define SPAN_MAX_SEL 4'ha
`define OSC_FREQ_HZ 1000
`endif

/* include/watchdog_pkg.sv */
package watchdog_pkg;
    typedef struct packed {
        logic [3:0] timeout_length_sel;
        logic enable;
    } main_cfg_t;

    typedef struct packed {
        logic [3:0] closed_span_sel;
        logic window_en;
    } window_cfg_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_CLOSED = 2'h1,
        ST_OPEN = 2'h3
    } wd_state_t;
endpackage : watchdog_pkg

/* logic/windowed_watchdog_timer.sv */
`timescale 1ns/10ps
`include "watchdog_cfg.svh"

module windowed_watchdog_timer (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic unlock_window_i,
    input wire logic lock_fuse_i,
    input wire logic [3:0] timeout_fuse_bits_i,
    input wire logic [3:0] closed_fuse_bits_i,
    input wire logic enable_fuse_i,
    input wire logic window_fuse_i,
    input wire logic low_power_osc_i,
    input wire logic watchdog_kick_instr_i,
    output logic watchdog_reset_o
);

    // ------------------------------------------------------------
    // Span decoding
    // ------------------------------------------------------------
    function automatic logic span_valid(input logic [3:0] sel);
        span_valid = (sel <= `SPAN_MAX_SEL);
    endfunction : span_valid

    function automatic logic [13:0] span_len(input logic [3:0] sel);
        span_len = `SPAN_BASE << sel;
    endfunction : span_len

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    watchdog_pkg::main_cfg_t main_q;
    watchdog_pkg::main_cfg_t main_d;
    watchdog_pkg::window_cfg_t win_q;
    watchdog_pkg::window_cfg_t win_d;
    watchdog_pkg::main_cfg_t act_main_q;
    watchdog_pkg::window_cfg_t act_win_q;
    watchdog_pkg::wd_state_t state_q;
    watchdog_pkg::wd_state_t state_d;
    logic main_gate_q;
    logic main_gate_d;
    logic win_gate_q;
    logic win_gate_d;
    logic busy_q;
    logic busy_d;
    logic ack_q;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic osc_meta_q;
    logic osc_sync_q;
    logic osc_prev_q;
    logic [13:0] cnt_q;
    logic [13:0] cnt_d;
    logic reset_q;
    logic reset_d;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic bus_req;
    wire logic bus_wr;
    wire logic [1:0] reg_idx;
    wire logic in_map;
    wire logic wr_main;
    wire logic wr_win;
    wire logic take_main;
    wire logic take_win;
    wire logic take_closed_span_sel;

    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];
    assign reg_idx = wb_adr_i[3:2];
    assign in_map = (wb_adr_i[7:4] == 4'h0) && (wb_adr_i[1:0] == 2'h0);
    assign wr_main = bus_wr & in_map & (reg_idx == `MAIN_IDX);
    assign wr_win = bus_wr & in_map & (reg_idx == `WINDOW_IDX);
    // Unlock plus change bit in the same write
    assign take_main = wr_main & unlock_window_i & wb_dat_i[`GATE_POS] & ~lock_fuse_i; // see R05 R06 R12 R14
    assign take_win = wr_win & unlock_window_i & wb_dat_i[`GATE_POS]; // see R05 R17 R19
    assign take_closed_span_sel = take_win & ~lock_fuse_i; // see R08

    // ------------------------------------------------------------
    // Register write paths
    // ------------------------------------------------------------
    always_comb begin
        main_d = main_q;
        main_gate_d = main_gate_q;
        if (take_main) begin
            main_d.timeout_length_sel = wb_dat_i[`SEL_POS +: 4]; // see R09 R12
            main_d.enable = wb_dat_i[`FLAG_POS]; // see R13
            main_gate_d = 1'b1;
        end
    end

    always_comb begin
        win_d = win_q;
        win_gate_d = win_gate_q;
        if (take_win) begin
            win_d.window_en = wb_dat_i[`FLAG_POS]; // see R18
            win_gate_d = 1'b1;
        end
        if (take_closed_span_sel) begin
            win_d.closed_span_sel = wb_dat_i[`SEL_POS +: 4]; // see R15
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    wire logic [7:0] main_rd;
    wire logic [7:0] win_rd;
    wire logic [7:0] stat_rd;

    // Reserved upper bits read as zero
    assign main_rd = {2'h0, main_q.timeout_length_sel, main_q.enable, main_gate_q}; // see R22
    assign win_rd = {2'h0, win_q.closed_span_sel, win_q.window_en, win_gate_q}; // see R22
    assign stat_rd = {7'h00, busy_q}; // see R20 R22

    always_comb begin
        rdat_d = 32'h0000_0000;
        if (bus_req && !wb_we_i && in_map) begin
            case (reg_idx)
                `MAIN_IDX: rdat_d = {24'h00_0000, main_rd};
                `WINDOW_IDX: rdat_d = {24'h00_0000, win_rd};
                `STATUS_IDX: rdat_d = {24'h00_0000, stat_rd};
                default: rdat_d = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Oscillator tick
    // ------------------------------------------------------------
    wire logic tick;

    assign tick = osc_sync_q & ~osc_prev_q; // see R04

    always_ff @(posedge clock_i) begin
        osc_meta_q <= low_power_osc_i;
        osc_sync_q <= osc_meta_q;
        osc_prev_q <= osc_sync_q;
    end

    // ------------------------------------------------------------
    // Domain crossing
    // ------------------------------------------------------------
    wire logic xfer;

    // Transfer on a tick, only while enabled (either copy)
    assign xfer = busy_q & tick & (main_q.enable | act_main_q.enable); // see R21

    // A new write in the same cycle keeps the flag set
    assign busy_d = take_main | take_win | (busy_q & ~xfer); // see R20

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    wire logic closed_ok;
    wire logic open_ok;
    wire logic [13:0] closed_len;
    wire logic [13:0] open_len;
    wire logic [13:0] cnt_inc;
    wire watchdog_pkg::wd_state_t start_state;

    assign closed_ok = act_win_q.window_en & span_valid(act_win_q.closed_span_sel); // see R15 R16
    assign open_ok = span_valid(act_main_q.timeout_length_sel); // see R11
    assign closed_len = span_len(act_win_q.closed_span_sel);
    assign open_len = span_len(act_main_q.timeout_length_sel); // see R10
    assign cnt_inc = cnt_q + 14'h0001;
    assign start_state = closed_ok ? watchdog_pkg::ST_CLOSED : watchdog_pkg::ST_OPEN; // see R26

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        reset_d = 1'b0;
        case (state_q)
            watchdog_pkg::ST_IDLE: begin
                cnt_d = 14'h0000;
                if (act_main_q.enable) begin
                    state_d = start_state;
                end
            end
            watchdog_pkg::ST_CLOSED: begin
                if (!closed_ok) begin
                    state_d = watchdog_pkg::ST_OPEN; // see R15 R16
                    cnt_d = 14'h0000;
                end else if (watchdog_kick_instr_i) begin
                    reset_d = 1'b1; // see R01 R25
                    state_d = start_state;
                    cnt_d = 14'h0000;
                end else if (tick) begin
                    cnt_d = cnt_inc;
                    if (cnt_inc >= closed_len) begin
                        state_d = watchdog_pkg::ST_OPEN; // see R02
                        cnt_d = 14'h0000;
                    end
                end
            end
            watchdog_pkg::ST_OPEN: begin
                if (watchdog_kick_instr_i) begin
                    state_d = start_state; // see R24 R26
                    cnt_d = 14'h0000;
                end else if (tick && open_ok) begin
                    cnt_d = cnt_inc;
                    if (cnt_inc >= open_len) begin
                        reset_d = 1'b1; // see R23 R25
                        state_d = start_state; // see R07
                        cnt_d = 14'h0000;
                    end
                end
            end
            default: begin
                state_d = watchdog_pkg::ST_IDLE;
                cnt_d = 14'h0000;
            end
        endcase
        if (!act_main_q.enable) begin
            state_d = watchdog_pkg::ST_IDLE; // see R13
            cnt_d = 14'h0000;
            reset_d = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Flip-flops
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            main_q <= '{timeout_length_sel: timeout_fuse_bits_i, enable: enable_fuse_i}; // see R03
            win_q <= '{closed_span_sel: closed_fuse_bits_i, window_en: window_fuse_i}; // see R03
            main_gate_q <= 1'b0; // see R14
            win_gate_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            main_q <= main_d;
            win_q <= win_d;
            main_gate_q <= main_gate_d;
            win_gate_q <= win_gate_d;
            busy_q <= busy_d;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            act_main_q <= '{timeout_length_sel: timeout_fuse_bits_i, enable: enable_fuse_i};
            act_win_q <= '{closed_span_sel: closed_fuse_bits_i, window_en: window_fuse_i};
        end else if (xfer) begin
            act_main_q <= main_q; // see R27
            act_win_q <= win_q;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state_q <= watchdog_pkg::ST_IDLE;
            cnt_q <= 14'h0000;
            reset_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            reset_q <= reset_d;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= bus_req;
            rdat_q <= rdat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign watchdog_reset_o = reset_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_busy_set;
        @(posedge clock_i) disable iff (srst_i)
        (take_main || take_win) |=> busy_q;
    endproperty
    a_busy_set: assert property (p_busy_set) else $error("busy flag not set after write"); // see R20

    property p_lock_main;
        @(posedge clock_i) disable iff (srst_i)
        (lock_fuse_i && wr_main) |=> $stable(main_q);
    endproperty
    a_lock_main: assert property (p_lock_main) else $error("main control changed while locked"); // see R06

    property p_main_gate;
        @(posedge clock_i) disable iff (srst_i)
        (wr_main && !wb_dat_i[`GATE_POS]) |=> $stable(main_q);
    endproperty
    a_main_gate: assert property (p_main_gate) else $error("main control changed without change bit"); // see R12

    property p_win_gate;
        @(posedge clock_i) disable iff (srst_i)
        (wr_win && !wb_dat_i[`GATE_POS]) |=> $stable(win_q);
    endproperty
    a_win_gate: assert property (p_win_gate) else $error("window control changed without change bit"); // see R17

    property p_lock_closed_span_sel;
        @(posedge clock_i) disable iff (srst_i)
        (lock_fuse_i && take_win) |=> $stable(win_q.closed_span_sel) && (win_q.window_en == $past(wb_dat_i[1]));
    endproperty
    a_lock_closed_span_sel: assert property (p_lock_closed_span_sel) else $error("locked window write misbehaved"); // see R08

    property p_closed_kick;
        @(posedge clock_i) disable iff (srst_i)
        (state_q == watchdog_pkg::ST_CLOSED && closed_ok && watchdog_kick_instr_i && act_main_q.enable)
            |=> watchdog_reset_o;
    endproperty
    a_closed_kick: assert property (p_closed_kick) else $error("early kick gave no reset"); // see R01

    property p_no_closed;
        @(posedge clock_i) disable iff (srst_i)
        (state_q == watchdog_pkg::ST_CLOSED && !closed_ok && act_main_q.enable)
            |=> (state_q == watchdog_pkg::ST_OPEN) && !watchdog_reset_o;
    endproperty
    a_no_closed: assert property (p_no_closed) else $error("closed window kept without valid span"); // see R16

    property p_open_expire;
        @(posedge clock_i) disable iff (srst_i)
        (state_q == watchdog_pkg::ST_OPEN && tick && open_ok && !watchdog_kick_instr_i && act_main_q.enable
            && cnt_inc >= open_len) |=> watchdog_reset_o;
    endproperty
    a_open_expire: assert property (p_open_expire) else $error("timeout gave no reset"); // see R23

    property p_open_kick;
        @(posedge clock_i) disable iff (srst_i)
        (state_q == watchdog_pkg::ST_OPEN && watchdog_kick_instr_i && act_main_q.enable)
            |=> (cnt_q == 14'h0000) && !watchdog_reset_o;
    endproperty
    a_open_kick: assert property (p_open_kick) else $error("kick did not restart the period"); // see R24

    property p_busy_hold;
        @(posedge clock_i) disable iff (srst_i)
        (busy_q && !main_q.enable && !act_main_q.enable) |=> busy_q;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("crossing done while disabled"); // see R21

    property p_reserved_open;
        @(posedge clock_i) disable iff (srst_i)
        (!act_win_q.window_en && !open_ok) |=> !watchdog_reset_o;
    endproperty
    a_reserved_open: assert property (p_reserved_open) else $error("reserved timeout gave reset"); // see R11

    property p_disabled_idle;
        @(posedge clock_i) disable iff (srst_i)
        !act_main_q.enable |=> (state_q == watchdog_pkg::ST_IDLE) && !watchdog_reset_o;
    endproperty
    a_disabled_idle: assert property (p_disabled_idle) else $error("disabled watchdog still counting"); // see R13

    property p_hold_old;
        @(posedge clock_i) disable iff (srst_i)
        !xfer |=> $stable(act_main_q) && $stable(act_win_q);
    endproperty
    a_hold_old: assert property (p_hold_old) else $error("settings changed before crossing"); // see R27

    property p_closed_to_open;
        @(posedge clock_i) disable iff (srst_i)
        (state_q == watchdog_pkg::ST_CLOSED && tick && !watchdog_kick_instr_i && act_main_q.enable
            && cnt_inc >= closed_len) |=> (state_q == watchdog_pkg::ST_OPEN) && (cnt_q == 14'h0000);
    endproperty
    a_closed_to_open: assert property (p_closed_to_open) else $error("open window did not follow"); // see R02

    property p_ack_pulse;
        @(posedge clock_i) disable iff (srst_i)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

endmodule : windowed_watchdog_timer

/* verif/windowed_watchdog_timer_tb_top.sv */
`timescale 1ns/10ps

module windowed_watchdog_timer_tb_top;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic unlock = 1'b0;
    logic lock = 1'b0;
    logic osc = 1'b0;
    logic run = 1'b1;
    logic kick = 1'b0;
    logic wd_rst;
    logic [2:0] tc = 3'h0;
    int error_cnt = 0;
    int checks_done = 0;
    int rst_cnt = 0;
    int cycles = 0;
    int n;

    initial begin
        forever #50 clock_i = ~clock_i;
    end

    windowed_watchdog_timer windowed_watchdog_timer_i (
        .clock_i(clock_i), .srst_i(srst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .unlock_window_i(unlock), .lock_fuse_i(lock), .timeout_fuse_bits_i(4'h1),
        .closed_fuse_bits_i(4'h2), .enable_fuse_i(1'b1), .window_fuse_i(1'b0),
        .low_power_osc_i(osc), .watchdog_kick_instr_i(kick), .watchdog_reset_o(wd_rst)
    );

    // Oscillator of 8 clocks a period, counter of reset pulses, run ceiling
    always @(posedge clock_i) begin
        tc <= tc + 3'h1;
        osc <= run & tc[2];
        cycles <= cycles + 1;
        if (wd_rst === 1'b1) begin
            rst_cnt <= rst_cnt + 1;
        end
        if (cycles == 30000) begin
            error_cnt = error_cnt + 1;
            print_verdict();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic print_verdict();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        checks_done++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : chk_rng

    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
        int t;
        t = 0;
        @(posedge clock_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        wdat <= {24'h0, d};
        do begin
            @(posedge clock_i);
            t++;
        end while (ack !== 1'b1 && t < 100);
        chk("bus ack", 32'h1, {31'h0, ack});
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [31:0] q;
        wb(1'b0, a, 8'h00, q);
        chk(what, {24'h0, exp}, q);
    endtask : rd_chk

    task automatic wait_idle();
        logic [31:0] q;
        int t;
        t = 0;
        do begin
            wb(1'b0, 8'h08, 8'h00, q);
            t++;
        end while (q[0] !== 1'b0 && t < 100);
        chk("busy clear", 32'h0, q);
    endtask : wait_idle

    task automatic gap(output int c);
        c = 0;
        do begin
            @(posedge clock_i);
            c++;
        end while (wd_rst !== 1'b1 && c < 5000);
        // Let the pulse counter take this pulse before anyone reads it
        @(posedge clock_i);
    endtask : gap

    task automatic pulse_kick();
        @(posedge clock_i);
        kick <= 1'b1;
        @(posedge clock_i);
        kick <= 1'b0;
    endtask : pulse_kick

    task automatic quiet(input int c, input string what);
        int base;
        base = rst_cnt;
        repeat (c) @(posedge clock_i);
        chk_rng(what, 0, 0, rst_cnt - base);
    endtask : quiet

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        int base;
        repeat (8) @(posedge clock_i);
        srst_i <= 1'b0;
        rd_chk(8'h00, 8'h06, "main reset");
        rd_chk(8'h04, 8'h08, "window reset");
        rd_chk(8'h08, 8'h00, "status reset");
        rd_chk(8'h0c, 8'h00, "unmapped");
        pulse_kick();
        gap(n);
        chk_rng("normal timeout", 120, 140, n);
        base = rst_cnt;
        repeat (6) begin
            repeat (64) @(posedge clock_i);
            pulse_kick();
        end
        chk_rng("kicked resets", 0, 0, rst_cnt - base);
        wr(8'h00, 8'h03);
        rd_chk(8'h00, 8'h06, "no unlock");
        unlock <= 1'b1;
        wr(8'h00, 8'h02);
        rd_chk(8'h00, 8'h06, "no change bit");
        run <= 1'b0;
        repeat (16) @(posedge clock_i);
        wr(8'h00, 8'h03);
        rd_chk(8'h08, 8'h01, "busy set");
        rd_chk(8'h00, 8'h03, "main written");
        run <= 1'b1;
        wait_idle();
        pulse_kick();
        gap(n);
        chk_rng("code 0 timeout", 56, 76, n);
        lock <= 1'b1;
        wr(8'h00, 8'h07);
        rd_chk(8'h00, 8'h03, "locked main");
        wr(8'h04, 8'h03);
        rd_chk(8'h04, 8'h0b, "locked window");
        wait_idle();
        lock <= 1'b0;
        wr(8'h04, 8'h03);
        rd_chk(8'h04, 8'h03, "window written");
        wait_idle();
        gap(n);
        gap(n);
        chk_rng("window total", 120, 140, n);
        repeat (16) @(posedge clock_i);
        pulse_kick();
        gap(n);
        chk_rng("early kick", 0, 4, n);
        repeat (96) @(posedge clock_i);
        pulse_kick();
        gap(n);
        chk_rng("open kick", 120, 140, n);
        wr(8'h00, 8'h2f);
        wait_idle();
        wr(8'h04, 8'h2f);
        wait_idle();
        pulse_kick();
        quiet(400, "reserved codes");
        wr(8'h04, 8'h01);
        wait_idle();
        wr(8'h00, 8'h01);
        wait_idle();
        quiet(400, "disabled");
        wr(8'h00, 8'h05);
        repeat (64) @(posedge clock_i);
        rd_chk(8'h08, 8'h01, "busy held");
        print_verdict();
    end
endmodule : windowed_watchdog_timer_tb_top
